//--- verilog/dpc_power_ctrl.sv
`timescale 1ns/1ps
// Power state and DLL mode controller of the memory device
// Operation
// RL1: Action chosen from clock-enable at previous and current edge plus current command.
// RL2: Controller holds a new clock-enable level until minimum pulse time less one clock.
// RL3: Controller lowers clock-enable only after register command and update delays.
// RL4: Only no-operation or deselect on power-down entry or exit edge.
// RL5: Falling clock-enable mid operation: precharge power-down if banks closed, else active.
// RL6: No refresh happens during power-down; controller must exit in time.
// RL7: Self-refresh entered only from all-idle with refresh and clock-enable falling.
// RL8: Controller never enters self-refresh during a read or write burst.
// RL9: Idle means banks closed, no burst, clock-enable high, all timings expired.
// RL10: Only no-operation or deselect on the self-refresh exit edge.
// RL11: After self-refresh exit, only no-operation or deselect until exit time passes.
// RL12: After self-refresh exit, no read or termination until DLL-locked exit time.
// RL13: First write no earlier than 512 clocks after self-refresh exit.
// RL14: Controller never produces unlisted state and command combinations.
// RL15: No-operation registers nothing and leaves running operations alone.
// RL16: Deselect ignores command lines; running operations continue.
// RL17: Mode register 1 bit A0 set disables the DLL until cleared.
// RL18: DLL-off mode supports only CAS latency 6 with write latency 6.
// RL19: DLL-off read strobe reference starts at additive plus CAS latency minus one.
// RL20: DLL-off switch: idle, disable bit, wait, self-refresh, clock stop, new frequency.
// RL21: During DLL-off switch, clock-enable high and termination low until updates done.
// RL22: DLL-on switch: exit wait, enable bit, delay, DLL reset, delay, latencies.
// RL23: During DLL-on switch, clock-enable high and termination low until DLL lock.
// RL24: Wait DLL lock, and calibration time if long calibration, before locked commands.
// RL25: Reset pin kept high in normal function, used only for asynchronous reset; this block takes reset active high, synchronous to ref_clk.
module dpc_power_ctrl (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    cke,
  input  wire logic                    cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [2:0]              bank_addr,
  input  wire logic [15:0]             addr,
  output logic                         dll_off_q,
  output logic                         dll_reset_req_q,
  output logic                         latency_bad_q,
  output logic [3:0]                   read_strobe_lat_q,
  output dpc_pkg::dpc_state_type       state_q,
  output logic                         idle_q,
  output logic                         refresh_allowed_q,
  output logic                         illegal_cmd_q
);
  import dpc_pkg::*;

  // Decoded command at this edge
  logic is_idle_cmd;
  logic is_mrs;
  logic is_ref;
  logic is_pre;
  logic is_act;
  logic is_wr;
  logic is_rd;

  // Calibration is decoded but carries no timing of its own in this block
  dpc_cmd_decode u_dec (
    .cs_n        (cs_n),
    .ras_n       (ras_n),
    .cas_n       (cas_n),
    .we_n        (we_n),
    .is_idle_cmd (is_idle_cmd),
    .is_mrs      (is_mrs),
    .is_ref      (is_ref),
    .is_pre      (is_pre),
    .is_act      (is_act),
    .is_wr       (is_wr),
    .is_rd       (is_rd),
    .is_zq       ()
  );

  // Command and exit timers shared by the idle test
  logic mod_done;
  logic burst_done;
  logic rp_done;
  logic xs_done;
  logic xp_done;
  logic mod_load;
  logic burst_load;
  logic rp_load;
  logic xs_load;
  logic xp_load;

  dpc_timer u_tmod (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (mod_load),
    .value   (TMR_W'(T_MOD_CYC > T_MRD_NCK ? T_MOD_CYC : T_MRD_NCK)),
    .done    (mod_done)
  );

  dpc_timer u_tburst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (burst_load),
    .value   (TMR_W'(T_BURST_CYC)),
    .done    (burst_done)
  );

  dpc_timer u_trp (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (rp_load),
    .value   (TMR_W'(T_RP_CYC)),
    .done    (rp_done)
  );

  dpc_timer u_txs (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (xs_load),
    .value   (TMR_W'(T_XS_CYC)),
    .done    (xs_done)
  );

  dpc_timer u_txp (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (xp_load),
    .value   (TMR_W'(T_XP_CYC)),
    .done    (xp_done)
  );

  // Power state group
  logic             cke_prev_q;
  logic [BANKS-1:0] bank_open_q;
  dpc_state_type    state_d;
  logic             cke_prev_d;
  logic [BANKS-1:0] bank_open_d;
  logic             illegal_d;
  logic             banks_closed;

  assign banks_closed = (bank_open_d == '0);

  // Timer reloads follow the commands that start each timing
  always_comb begin
    mod_load   = is_mrs && cke_prev_q && cke;
    burst_load = (is_rd || is_wr) && cke_prev_q && cke;
    rp_load    = is_pre && cke_prev_q && cke;
    xs_load    = (state_q == ST_SREF) && !cke_prev_q && cke;
    xp_load    = ((state_q == ST_PPD) || (state_q == ST_APD)) && !cke_prev_q && cke;
  end

  // Bank bookkeeping and state decision from both clock-enable samples
  always_comb begin
    state_d     = state_q;
    cke_prev_d  = cke;
    bank_open_d = bank_open_q;
    illegal_d   = 1'b0;
    if (cke_prev_q && cke) begin
      if (is_act) begin
        bank_open_d[bank_addr] = 1'b1;
      end else if (is_pre) begin
        if (addr[10]) begin
          bank_open_d = '0;
        end else begin
          bank_open_d[bank_addr] = 1'b0;
        end
      end
    end
    unique case (state_q)
      ST_IDLE, ST_ACTIVE: begin
        if (cke_prev_q && !cke) begin // RL1
          if (is_ref && state_q == ST_IDLE && idle_q) begin
            state_d = ST_SREF; // RL7
          end else if (is_idle_cmd) begin
            state_d = banks_closed ? ST_PPD : ST_APD; // RL5
          end else begin
            illegal_d = 1'b1; // RL14
          end
        end else if (cke_prev_q && cke) begin
          state_d = banks_closed ? ST_IDLE : ST_ACTIVE;
        end else if (cke && !is_idle_cmd) begin
          illegal_d = 1'b1; // RL14
        end
      end
      ST_PPD, ST_APD: begin
        if (!cke_prev_q && cke) begin // RL1
          if (is_idle_cmd) begin
            state_d = banks_closed ? ST_IDLE : ST_ACTIVE;
          end else begin
            illegal_d = 1'b1; // RL4
          end
        end
      end
      ST_SREF: begin
        if (!cke_prev_q && cke) begin
          if (is_idle_cmd) begin
            state_d = ST_IDLE;
          end else begin
            illegal_d = 1'b1; // RL10
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q       <= ST_IDLE;
      cke_prev_q    <= 1'b0;
      bank_open_q   <= '0;
      illegal_cmd_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      cke_prev_q    <= cke_prev_d;
      bank_open_q   <= bank_open_d;
      illegal_cmd_q <= illegal_d;
    end
  end

  // Idle and refresh status group
  logic idle_d;
  logic refresh_allowed_d;

  // Idle needs every timing expired, not just banks closed
  // A timer loading on this edge still reads done, so its load must block idle too
  always_comb begin
    idle_d = (state_d == ST_IDLE) && cke && mod_done && burst_done && rp_done
             && xs_done && xp_done && !mod_load && !burst_load && !rp_load
             && !xs_load && !xp_load; // RL9
    refresh_allowed_d = !((state_d == ST_PPD) || (state_d == ST_APD)); // RL6
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idle_q            <= 1'b0;
      refresh_allowed_q <= 1'b1;
    end else begin
      idle_q            <= idle_d;
      refresh_allowed_q <= refresh_allowed_d;
    end
  end

  // DLL mode and latency group
  logic       dll_off_d;
  logic       dll_reset_req_d;
  logic       latency_bad_d;
  logic [3:0] cl_q;
  logic [3:0] cwl_q;
  logic [3:0] al_q;
  logic [3:0] cl_d;
  logic [3:0] cwl_d;
  logic [3:0] al_d;
  logic [3:0] read_strobe_lat_d;

  // Mode writes only take effect on a registered command with clock-enable high
  always_comb begin
    dll_off_d       = dll_off_q;
    cl_d            = cl_q;
    cwl_d           = cwl_q;
    al_d            = al_q;
    dll_reset_req_d = 1'b0;
    if (mod_load) begin
      unique case (bank_addr)
        MR_SEL_1: begin
          dll_off_d = addr[MR1_DLL_OFF_BIT]; // RL17
          al_d      = {2'h0, addr[4:3]};
        end
        MR_SEL_0: begin
          cl_d            = addr[MR0_CL_LSB +: 4];
          dll_reset_req_d = addr[MR0_DLL_RST_BIT]; // RL22
        end
        MR_SEL_2: begin
          cwl_d = {1'b0, addr[MR2_CWL_LSB +: 3]};
        end
        default: begin
          dll_off_d = dll_off_q;
        end
      endcase
    end
    // Flagged, not corrected: the device cannot fix a bad controller setting
    latency_bad_d = dll_off_d && ((cl_d != DLL_OFF_CL) || (cwl_d != DLL_OFF_CWL)); // RL18
    // Strobe reference one clock earlier with the DLL off
    read_strobe_lat_d = dll_off_d ? 4'(al_d + cl_d - 4'h1) : 4'(al_d + cl_d); // RL19
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dll_off_q         <= 1'b0;
      dll_reset_req_q   <= 1'b0;
      latency_bad_q     <= 1'b0;
      read_strobe_lat_q <= 4'(AL_RESET + CL_RESET);
      cl_q              <= CL_RESET;
      cwl_q             <= CWL_RESET;
      al_q              <= AL_RESET;
    end else begin
      dll_off_q         <= dll_off_d;
      dll_reset_req_q   <= dll_reset_req_d;
      latency_bad_q     <= latency_bad_d;
      read_strobe_lat_q <= read_strobe_lat_d;
      cl_q              <= cl_d;
      cwl_q             <= cwl_d;
      al_q              <= al_d;
    end
  end

endmodule : dpc_power_ctrl

//--- verilog/dpc_pkg.sv
// Package of constants and types for the power state and DLL mode controller
package dpc_pkg;

  // Command strobe encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS     = 4'h0;
  localparam logic [3:0] CMD_REF     = 4'h1;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_ACT     = 4'h3;
  localparam logic [3:0] CMD_WR      = 4'h4;
  localparam logic [3:0] CMD_RD      = 4'h5;
  localparam logic [3:0] CMD_ZQ      = 4'h6;
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CS_DESEL_MASK = 4'h8;

  // Mode register selects and bit positions
  localparam logic [2:0] MR_SEL_0    = 3'h0;
  localparam logic [2:0] MR_SEL_1    = 3'h1;
  localparam logic [2:0] MR_SEL_2    = 3'h2;
  localparam int         MR1_DLL_OFF_BIT = 0;
  localparam int         MR0_DLL_RST_BIT = 8;
  localparam int         MR0_CL_LSB  = 4;
  localparam int         MR2_CWL_LSB = 3;

  // DLL-off only supported latency pair, as encoded values
  localparam logic [3:0] DLL_OFF_CL  = 4'h6;
  localparam logic [3:0] DLL_OFF_CWL = 4'h6;
  localparam logic [3:0] CL_RESET    = 4'h6;
  localparam logic [3:0] CWL_RESET   = 4'h6;
  localparam logic [3:0] AL_RESET    = 4'h0;

  // Timings in clock cycles at 200 MHz (5 ns)
  localparam int         CLK_PERIOD_PS = 5000;
  localparam int         T_MRD_NCK   = 4;
  localparam int         T_MOD_NS    = 15;
  localparam int         T_MOD_CYC   = (T_MOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         T_BURST_CYC = 4;
  localparam int         T_RP_CYC    = 3;
  localparam int         T_XS_NS     = 170;
  localparam int         T_XS_CYC    = (T_XS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         T_XP_NS     = 6;
  localparam int         T_XP_CYC    = (T_XP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         T_WR_AFTER_SRX_NCK = 512;
  localparam int         TMR_W       = 10;
  localparam int         BANKS       = 8;

  // Power state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ACTIVE = 5'b00010,
    ST_PPD    = 5'b00100,
    ST_APD    = 5'b01000,
    ST_SREF   = 5'b10000
  } dpc_state_type;

endpackage : dpc_pkg

//--- verilog/dpc_timer.sv
`timescale 1ns/1ps
// Loadable down-counter reporting when a timing has expired
module dpc_timer (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic                       load,
  input  wire logic [dpc_pkg::TMR_W-1:0]  value,
  output logic                            done
);
  import dpc_pkg::*;

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // Next count: reload wins over counting down
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);

endmodule : dpc_timer

//--- verilog/dpc_cmd_decode.sv
`timescale 1ns/1ps
// Command strobe decoder; deselect and no-operation register nothing
module dpc_cmd_decode (
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  output logic            is_idle_cmd,
  output logic            is_mrs,
  output logic            is_ref,
  output logic            is_pre,
  output logic            is_act,
  output logic            is_wr,
  output logic            is_rd,
  output logic            is_zq
);
  import dpc_pkg::*;

  logic [3:0] code;

  // Chip select high masks the other strobes entirely
  always_comb begin
    code        = {cs_n, ras_n, cas_n, we_n};
    is_idle_cmd = cs_n || (code == CMD_NOP); // RL15 RL16
    is_mrs      = !cs_n && (code == CMD_MRS);
    is_ref      = !cs_n && (code == CMD_REF);
    is_pre      = !cs_n && (code == CMD_PRE);
    is_act      = !cs_n && (code == CMD_ACT);
    is_wr       = !cs_n && (code == CMD_WR);
    is_rd       = !cs_n && (code == CMD_RD);
    is_zq       = !cs_n && (code == CMD_ZQ);
  end

endmodule : dpc_cmd_decode

//--- tb/dpc_power_ctrl_chk.sv
// Checker of power state and DLL mode behaviour at the controller ports
`timescale 1ns/1ps
module dpc_power_ctrl_chk
  import dpc_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          reset,
  input wire logic          cke,
  input wire logic          cs_n,
  input wire logic          ras_n,
  input wire logic          cas_n,
  input wire logic          we_n,
  input wire logic [2:0]    bank_addr,
  input wire logic [15:0]   addr,
  input wire logic          dll_off_q,
  input wire logic          latency_bad_q,
  input wire logic [3:0]    read_strobe_lat_q,
  input wire dpc_state_type state_q,
  input wire logic          idle_q,
  input wire logic          refresh_allowed_q,
  input wire logic          illegal_cmd_q
);
  // Command word and the no-operation or deselect case
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic nopdes = cs_n || (cmd == CMD_NOP);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_DLL_OFF: assert property (
    cke && $past(cke) && state_q == ST_IDLE && idle_q && cmd == CMD_MRS && bank_addr == MR_SEL_1
    |=> dll_off_q == $past(addr[0])) else $error("dll off bit not taken");
  AST_LAT_BAD: assert property (latency_bad_q |-> dll_off_q) else $error("latency flag with dll on");
  AST_SRE: assert property (
    state_q == ST_IDLE && idle_q && $past(cke) && !cke && cmd == CMD_REF |=> state_q == ST_SREF)
    else $error("self refresh not entered");
  AST_SR_FROM_IDLE: assert property (
    state_q == ST_SREF && $past(state_q) != ST_SREF |-> $past(state_q) == ST_IDLE && $past(cmd) == CMD_REF)
    else $error("self refresh from wrong state");
  AST_PD_NOREF: assert property (
    state_q inside {ST_PPD, ST_APD} |-> !refresh_allowed_q) else $error("refresh in power down");
  AST_PD_HOLD: assert property (
    state_q inside {ST_PPD, ST_APD} && !cke |=> state_q == $past(state_q)) else $error("power down left");
  AST_APD_ENTRY: assert property (
    state_q == ST_ACTIVE && $past(cke) && !cke && nopdes |=> state_q inside {ST_APD, ST_PPD})
    else $error("no power down from active");
  AST_PPD_ENTRY: assert property (
    state_q == ST_IDLE && $past(cke) && !cke && nopdes |=> state_q == ST_PPD) else $error("no precharge pd");
  AST_ILLEGAL: assert property (
    cke != $past(cke) && !cs_n && cmd != CMD_NOP && cmd != CMD_REF
    |=> illegal_cmd_q && state_q == $past(state_q)) else $error("bad transition command taken");
  AST_IDLE_CMD: assert property (
    nopdes && cke && $past(cke) |=> $stable(dll_off_q) && $stable(read_strobe_lat_q))
    else $error("idle command changed mode");
  AST_SRX: assert property (
    state_q == ST_SREF && cke && !$past(cke) && nopdes |=> state_q == ST_IDLE && !idle_q ##1 !idle_q [*7])
    else $error("idle too soon after exit");
endmodule : dpc_power_ctrl_chk

//--- tb/dpc_host_model.sv
// Memory controller model driving clock enable, command strobes and address
`timescale 1ns/1ps
module dpc_host_model (
  input  wire logic   ref_clk,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  bank_addr,
  output logic [15:0] addr
);
  import dpc_pkg::*;

  // Idle lines at time zero
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
    bank_addr = 3'h0;
    addr = 16'h0000;
  end

  // One command per edge, launched after the edge and held a full cycle
  task automatic issue(input logic [3:0] cmd, input logic ck, input logic [2:0] ba, input logic [15:0] ad);
    @(posedge ref_clk);
    cke <= ck;
    {cs_n, ras_n, cas_n, we_n} <= cmd;
    bank_addr <= ba;
    addr <= ad;
  endtask : issue

  // Deselect; unselected lines wander so a stale value never passes
  task automatic hold(input int n, input logic ck);
    for (int i = 0; i < n; i++) begin
      issue({1'b1, i[2:0]}, ck, i[2:0], 16'hFFFF ^ i[15:0]);
    end
  endtask : hold
endmodule : dpc_host_model

//--- tb/testbench.sv
// Self-checking bench for the power state and DLL mode controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("Error %s expected %h seen %h", nm, e, g); n_mismatch++; end end
module testbench;
  import dpc_pkg::*;
  logic          ref_clk;
  logic          reset;
  logic          cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]    bank_addr;
  logic [15:0]   addr;
  logic          dll_off_q, dll_reset_req_q, latency_bad_q, idle_q, refresh_allowed_q, illegal_cmd_q;
  logic [3:0]    read_strobe_lat_q;
  dpc_state_type state_q;
  int            n_mismatch = 0;
  int            n_checks = 0;

  dpc_power_ctrl uut (.ref_clk(ref_clk), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr), .dll_off_q(dll_off_q),
    .dll_reset_req_q(dll_reset_req_q), .latency_bad_q(latency_bad_q), .read_strobe_lat_q(read_strobe_lat_q),
    .state_q(state_q), .idle_q(idle_q), .refresh_allowed_q(refresh_allowed_q), .illegal_cmd_q(illegal_cmd_q));
  dpc_host_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .addr(addr));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Command, then no-operation; outputs of the command are settled after
  task automatic go(input logic [3:0] cmd, input logic ck, input logic [2:0] ba, input logic [15:0] ad);
    ctl.issue(cmd, ck, ba, ad);
    ctl.issue(CMD_NOP, ck, 3'h0, 16'h0000);
    #1;
  endtask : go

  // Bounded wait for the idle flag; a stuck flag ends the run
  task automatic wait_idle;
    int i;
    for (i = 0; i < 300 && idle_q !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 300) begin
      n_mismatch++;
      final_report();
    end
    #1;
  endtask : wait_idle

  task automatic mrs(input logic [2:0] ba, input logic [15:0] ad);
    wait_idle();
    go(CMD_MRS, 1'b1, ba, ad);
  endtask : mrs

  task automatic t_reset;
    `CHK("state", ST_IDLE, state_q)
    `CHK("dll_off", 1'b0, dll_off_q)
    `CHK("refresh", 1'b1, refresh_allowed_q)
    `CHK("lat", AL_RESET + CL_RESET, read_strobe_lat_q)
  endtask : t_reset

  task automatic t_dll;
    ctl.hold(6, 1'b1);
    #1;
    `CHK("dll_off des", 1'b0, dll_off_q)
    `CHK("lat des", 4'(AL_RESET + CL_RESET), read_strobe_lat_q)
    mrs(MR_SEL_1, 16'h0001);
    `CHK("dll_off set", 1'b1, dll_off_q)
    `CHK("lat off", AL_RESET + CL_RESET - 4'h1, read_strobe_lat_q)
    `CHK("lat bad", 1'b0, latency_bad_q)
    mrs(MR_SEL_0, 16'h0070);
    `CHK("lat bad cl7", 1'b1, latency_bad_q)
    `CHK("lat cl7", 4'h6, read_strobe_lat_q)
    mrs(MR_SEL_0, 16'h0160);
    `CHK("dll reset", 1'b1, dll_reset_req_q)
    `CHK("lat bad cl6", 1'b0, latency_bad_q)
    mrs(MR_SEL_1, 16'h0000);
    `CHK("dll_off clr", 1'b0, dll_off_q)
    `CHK("lat on", 4'h6, read_strobe_lat_q)
  endtask : t_dll

  // Two self-refresh round trips: the first turns the DLL off, the second back on
  task automatic t_sref;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        mrs(MR_SEL_1, 16'h0001);
      end
      wait_idle();
      go(CMD_REF, 1'b0, 3'h0, 16'h0000);
      `CHK("sref entry", ST_SREF, state_q)
      ctl.hold(4, 1'b0);
      go(CMD_NOP, 1'b1, 3'h0, 16'h0000);
      `CHK("sref exit", ST_IDLE, state_q)
      `CHK("idle at exit", 1'b0, idle_q)
      ctl.hold(20, 1'b1);
      #1;
      `CHK("idle in exit time", 1'b0, idle_q)
      if (k == 1) begin
        mrs(MR_SEL_1, 16'h0000);
        `CHK("dll on", 1'b0, dll_off_q)
        mrs(MR_SEL_0, 16'h0160);
        `CHK("dll reset sr", 1'b1, dll_reset_req_q)
      end
      mrs(MR_SEL_0, 16'h0060);
      `CHK("dll mode", k == 0, dll_off_q)
      `CHK("lat bad sr", 1'b0, latency_bad_q)
      `CHK("lat sr", (k == 0) ? 4'(AL_RESET + DLL_OFF_CL - 4'h1) : 4'(AL_RESET + CL_RESET), read_strobe_lat_q)
      ctl.hold(T_WR_AFTER_SRX_NCK, 1'b1);
    end
  endtask : t_sref

  task automatic t_pd;
    wait_idle();
    go(CMD_ACT, 1'b1, 3'h2, 16'h0010);
    `CHK("act", ST_ACTIVE, state_q)
    ctl.hold(4, 1'b1);
    go(CMD_WR, 1'b1, 3'h2, 16'h0000);
    go(CMD_RD, 1'b1, 3'h2, 16'h0000);
    `CHK("rd", ST_ACTIVE, state_q)
    go(CMD_NOP, 1'b0, 3'h0, 16'h0000);
    `CHK("apd", ST_APD, state_q)
    `CHK("apd refresh", 1'b0, refresh_allowed_q)
    ctl.hold(4, 1'b0);
    go(CMD_NOP, 1'b1, 3'h0, 16'h0000);
    `CHK("apd exit", ST_ACTIVE, state_q)
    ctl.hold(4, 1'b1);
    ctl.issue(CMD_MRS, 1'b0, MR_SEL_1, 16'h0001);
    ctl.issue(CMD_NOP, 1'b1, 3'h0, 16'h0000);
    #1;
    `CHK("refused", 1'b1, illegal_cmd_q)
    `CHK("state kept", ST_ACTIVE, state_q)
    `CHK("dll kept", 1'b0, dll_off_q)
    ctl.hold(4, 1'b1);
    go(CMD_PRE, 1'b1, 3'h0, 16'h0400);
    wait_idle();
    go(CMD_NOP, 1'b0, 3'h0, 16'h0000);
    `CHK("ppd", ST_PPD, state_q)
    `CHK("ppd refresh", 1'b0, refresh_allowed_q)
    ctl.hold(4, 1'b0);
    go(CMD_NOP, 1'b1, 3'h0, 16'h0000);
    `CHK("ppd exit", ST_IDLE, state_q)
    `CHK("refresh back", 1'b1, refresh_allowed_q)
  endtask : t_pd

  // Reset for 12 cycles, then the scenarios in turn
  initial begin
    reset = 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    ctl.hold(2, 1'b1);
    #1;
    t_reset();
    t_dll();
    t_sref();
    t_pd();
    final_report();
  end
endmodule : testbench

bind dpc_power_ctrl dpc_power_ctrl_chk u_chk (.ref_clk, .reset, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .bank_addr, .addr, .dll_off_q, .latency_bad_q, .read_strobe_lat_q, .state_q, .idle_q,
  .refresh_allowed_q, .illegal_cmd_q);
